// >>> pcp_port.sv
// parallel capture port: gp and 656 modes, register port, pin sampling
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// R1: one clock, three syncs, sixteen data lines
// R2: port clock at most half system clock; the code needs two samples per level, so a quarter at most
// R3: each frame sync selectable input or output
// R4: gp mode one direction, up to 16 bits
// R5: 656 mode 8 or 10 bit samples
// R6: decode embedded line and field codes
// R7: input submode: syncs and data are inputs; the code drives the data lines when the direction bit is set
// R8: frame capture drives syncs, receives data; the code drives the data lines instead when the direction bit is set
// R9: capture: sync one hsync, sync two vsync
// R10: output submode drives data and syncs
// R11: input submode: sync one starts reading
// R12: wait programmed port clocks before data
// R13: samples per frame equal transfer count
// R14: width 8 or 10 through 16 bits
// R15: active mode drops blanking samples
// R16: active mode drops control codes
// R17: active mode waits for SAV after field1
// R18: active mode count is lines per frame
// R19: vblank mode passes only blanking samples
// R20: entire field passes every sample
// R21: entire field starts right after field1
// R22: codes are FF 00 00 then status
// R23: idle and undriven until enabled
module pcp_port
   import pcp_pkg::*;
#(
   parameter int DW = 16
) (
   // clock and reset
   input  wire logic          ref_clk_i,
   input  wire logic          rst_i,
   // register port
   input  wire logic [3:0]    addr_i,
   input  wire logic [15:0]   wdata_i,
   input  wire logic          wr_i,
   input  wire logic          rd_i,
   output logic      [15:0]   rdata_o,
   // link pins
   input  wire logic          port_clock_in_i,
   input  wire logic [2:0]    fs_i,
   output logic      [2:0]    fs_o,
   output logic      [2:0]    fs_oe_o,
   input  wire logic [DW-1:0] pd_i,
   output logic      [DW-1:0] pd_o,
   output logic      [DW-1:0] pd_oe_o,
   // system side stream
   output pcp_sample_t        rx_o,
   input  wire logic [DW-1:0] tx_data_i,
   output logic               tx_take_o,
   output logic               frame_done_o
);
   logic [15:0] port_configuration;
   logic [15:0] sync_to_data_delay;
   logic [15:0] transfer_count;
   logic        en, is656;
   pcp_xfr_t    xfr;
   pcp_vmode_t  vmode;
   logic [4:0]  width;
   logic [DW-1:0] wmask;
   assign en    = port_configuration[PCP_CFG_EN];
   assign is656 = port_configuration[PCP_CFG_656];
   assign xfr   = pcp_xfr_t'(port_configuration[PCP_CFG_XFR_HI:PCP_CFG_XFR_LO]);
   assign vmode = pcp_vmode_t'(port_configuration[PCP_CFG_XFR_HI:PCP_CFG_XFR_LO]);

   // width decode, 656 fixed at 8 or 10
   always_comb begin
      if (port_configuration[PCP_CFG_WID_HI:PCP_CFG_WID_LO] == PCP_WID_8) begin
         width = 5'h08; // R14 R5
      end else begin
         width = PCP_WID_BASE + {2'h0, port_configuration[PCP_CFG_WID_HI:PCP_CFG_WID_LO]}; // R14
      end
      if (is656 && width > 5'h0A) begin
         width = 5'h0A; // R5
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < DW; gi++) begin : g_mask
         assign wmask[gi] = (5'(gi) < width);
      end
   endgenerate

   // three-stage sampling of all link inputs
   logic [2:0]    clk_s;
   logic [2:0]    fs_s1, fs_s2, fs_s3;
   logic [DW-1:0] pd_s1, pd_s2, pd_s3;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         clk_s <= 3'h0;
         fs_s1 <= 3'h0;
         fs_s2 <= 3'h0;
         fs_s3 <= 3'h0;
         pd_s1 <= '0;
         pd_s2 <= '0;
         pd_s3 <= '0;
      end else begin
         clk_s <= {clk_s[1:0], port_clock_in_i}; // R1 R2
         fs_s1 <= fs_i;
         fs_s2 <= fs_s1;
         fs_s3 <= fs_s2;
         pd_s1 <= pd_i;
         pd_s2 <= pd_s1;
         pd_s3 <= pd_s2;
      end
   end
   // last level that the second and third stages agreed on
   logic          pclk_lvl;
   logic          fs1_lvl;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pclk_lvl <= 1'b0;
         fs1_lvl  <= 1'b0;
      end else begin
         if (clk_s[1] == clk_s[2]) begin
            pclk_lvl <= clk_s[2];
         end
         if (fs_s2[0] == fs_s3[0]) begin
            fs1_lvl <= fs_s3[0];
         end
      end
   end
   // an edge counts only once both late stages agree
   logic          pclk_rise;
   assign pclk_rise = clk_s[1] & clk_s[2] & ~pclk_lvl; // R1 R2
   // data taken from the stage that lines up with the clock edge
   logic [DW-1:0] din;
   assign din = pd_s3 & wmask;
   logic          fs1_rise;
   assign fs1_rise = fs_s2[0] & fs_s3[0] & ~fs1_lvl; // R11

   // register write
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         port_configuration <= PCP_CFG_RESET;
         sync_to_data_delay <= 16'h0000;
         transfer_count     <= 16'h0000;
      end else if (wr_i) begin
         if (addr_i == PCP_ADDR_CONFIG) begin
            port_configuration <= wdata_i;
         end else if (addr_i == PCP_ADDR_DELAY) begin
            sync_to_data_delay <= wdata_i;
         end else if (addr_i == PCP_ADDR_COUNT) begin
            transfer_count <= wdata_i;
         end
      end
   end

   // general purpose sequencer
   pcp_state_t  st;
   logic [15:0] dcnt, xcnt;
   logic        gp_act;
   assign gp_act = en && !is656;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st   <= PCP_ST_IDLE;
         dcnt <= 16'h0000;
         xcnt <= 16'h0000;
      end else if (!gp_act) begin
         st <= PCP_ST_IDLE; // R23
      end else begin
         case (st)
            PCP_ST_IDLE: begin
               st <= PCP_ST_WAIT;
            end
            PCP_ST_WAIT: begin
               // input waits on external sync, others self-pace
               if ((xfr == PCP_XFR_INPUT && fs1_rise) || (xfr != PCP_XFR_INPUT && pclk_rise)) begin // R11
                  dcnt <= 16'h0000;
                  xcnt <= 16'h0000;
                  st   <= PCP_ST_DELAY;
               end
            end
            PCP_ST_DELAY: begin
               if (dcnt >= sync_to_data_delay) begin
                  st <= PCP_ST_RUN; // R12
               end else if (pclk_rise) begin
                  dcnt <= dcnt + 16'h0001; // R12
               end
            end
            PCP_ST_RUN: begin
               if (xcnt >= transfer_count) begin
                  st <= PCP_ST_DONE; // R13
               end else if (pclk_rise) begin
                  xcnt <= xcnt + 16'h0001; // R13
               end
            end
            PCP_ST_DONE: begin
               st <= PCP_ST_WAIT;
            end
            default: st <= PCP_ST_IDLE;
         endcase
      end
   end
   logic gp_take;
   assign gp_take = (st == PCP_ST_RUN) && (xcnt < transfer_count) && pclk_rise;

   // 656 decoder
   logic [1:0] pre;
   logic       in_trs, f_bit, v_bit, h_bit, synced, seen_sav;
   logic [15:0] lines;
   logic [9:0]  w10;
   // 8-bit words: repeat the top bits so an all-ones word matches
   assign w10 = (width == 5'h08) ? {din[7:0], din[7:6]} : din[9:0]; // R5
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pre      <= 2'h0;
         in_trs   <= 1'b0;
         f_bit    <= 1'b0;
         v_bit    <= 1'b1;
         h_bit    <= 1'b1;
         synced   <= 1'b0;
         seen_sav <= 1'b0;
         lines    <= 16'h0000;
      end else if (!(en && is656)) begin
         pre    <= 2'h0;
         in_trs <= 1'b0;
         synced <= 1'b0;
         seen_sav <= 1'b0;
         lines  <= 16'h0000;
      end else if (pclk_rise) begin
         in_trs <= 1'b0;
         if (pre == 2'h3) begin
            // status word carries F, V, H
            in_trs <= 1'b1; // R22 R6
            f_bit  <= w10[PCP_TRS_F];
            v_bit  <= w10[PCP_TRS_V];
            h_bit  <= w10[PCP_TRS_H];
            pre    <= 2'h0;
            if (!w10[PCP_TRS_F] && !synced && w10[PCP_TRS_V]) begin
               synced <= 1'b1; // R17 R21
            end
            if (synced && !w10[PCP_TRS_H] && !w10[PCP_TRS_V]) begin
               seen_sav <= 1'b1; // R17
               lines    <= lines + 16'h0001; // R18
            end
            if (w10[PCP_TRS_F] != f_bit && !w10[PCP_TRS_F]) begin
               lines <= 16'h0000;
            end
         end else if (w10 == PCP_TRC_FF) begin
            pre <= 2'h1; // R22
         end else if (w10 == PCP_TRC_00 && pre != 2'h0) begin
            pre <= pre + 2'h1; // R22
         end else begin
            pre <= 2'h0;
         end
      end
   end
   logic ctrl_word, v_take;
   // preamble words and the status word
   assign ctrl_word = (w10 == PCP_TRC_FF) || (pre != 2'h0);
   always_comb begin
      v_take = 1'b0;
      if (en && is656 && synced && pclk_rise) begin
         case (vmode)
            PCP_V_ACTIVE: v_take = seen_sav && !ctrl_word && !h_bit && !v_bit
                                   && (lines <= transfer_count); // R15 R16 R18
            PCP_V_VBLANK: v_take = !ctrl_word && v_bit; // R19
            PCP_V_FIELD:  v_take = 1'b1; // R20 R21
            default:      v_take = 1'b0;
         endcase
      end
   end

   // receive and transmit data path
   logic rx_dir;
   assign rx_dir = !port_configuration[PCP_CFG_DIR] && xfr != PCP_XFR_OUTPUT; // R4
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_o <= '0;
      end else begin
         rx_o.valid <= (gp_take && rx_dir) || (v_take && !port_configuration[PCP_CFG_DIR]); // R7 R8
         rx_o.data  <= 16'(din); // R14
      end
   end
   assign tx_take_o = gp_take && !rx_dir;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pd_o <= '0;
      end else if (tx_take_o) begin
         pd_o <= tx_data_i & wmask; // R10
      end
   end
   // data lines driven only when enabled for output
   assign pd_oe_o = {DW{en && !rx_dir && !is656}}; // R23 R10 R4

   // frame sync drive: output, capture modes
   logic fs_drv;
   assign fs_drv = en && !is656 && (xfr != PCP_XFR_INPUT);
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fs_o <= 3'h0;
      end else begin
         fs_o[0] <= fs_drv && (st == PCP_ST_DELAY); // R9 hsync
         fs_o[1] <= fs_drv && (st == PCP_ST_DONE); // R9 vsync
         fs_o[2] <= fs_drv && (st == PCP_ST_DELAY) && (xfr == PCP_XFR_OUTPUT);
      end
   end
   assign fs_oe_o = fs_drv ? port_configuration[PCP_CFG_FSO_HI:PCP_CFG_FSO_LO] | {1'b0, xfr == PCP_XFR_CAPTURE, 1'b0}
                             | {2'b0, xfr == PCP_XFR_CAPTURE} : 3'h0; // R3 R7 R8
   assign frame_done_o = (st == PCP_ST_DONE);

   // register read, one cycle later
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         if (addr_i == PCP_ADDR_CONFIG) begin
            rdata_o <= port_configuration;
         end else if (addr_i == PCP_ADDR_DELAY) begin
            rdata_o <= sync_to_data_delay;
         end else if (addr_i == PCP_ADDR_COUNT) begin
            rdata_o <= transfer_count;
         end else if (addr_i == PCP_ADDR_STATUS) begin
            rdata_o <= {8'h00, synced, f_bit, v_bit, h_bit, 1'b0, st};
         end else begin
            rdata_o <= 16'h0000;
         end
      end
   end

   // assertions
   sequence s_sync_seen;
      en && !is656 && xfr == PCP_XFR_INPUT && st == PCP_ST_WAIT && fs1_rise;
   endsequence
   a_idle_undriven: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !en |-> (pd_oe_o == '0 && fs_oe_o == 3'h0)) else $error("driving while disabled"); // R23
   a_input_no_drive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (en && xfr == PCP_XFR_INPUT) |-> fs_oe_o == 3'h0) else $error("sync driven in input"); // R7
   a_sync_to_delay: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      s_sync_seen |=> st == PCP_ST_DELAY) else $error("sync not taken"); // R11
   a_delay_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (st == PCP_ST_DELAY && gp_act) |-> !gp_take) else $error("data before delay"); // R12
   a_count_bound: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      gp_take |-> xcnt < transfer_count) else $error("too many samples"); // R13
   a_capture_fs: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (en && !is656 && xfr == PCP_XFR_CAPTURE) |-> fs_oe_o[1:0] == 2'h3) else $error("capture syncs"); // R8
   a_field_all: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (en && is656 && vmode == PCP_V_FIELD && synced && pclk_rise) |-> v_take) else $error("sample lost"); // R20
   a_active_ctrl: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (vmode == PCP_V_ACTIVE && ctrl_word) |-> !v_take) else $error("code stored"); // R16

   // checker helpers: samples per frame, port clocks spent in delay
   logic [15:0] chk_takes;
   logic [15:0] chk_dly;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         chk_takes <= 16'h0000;
      end else if (st == PCP_ST_WAIT) begin
         chk_takes <= 16'h0000;
      end else if (gp_take) begin
         chk_takes <= chk_takes + 16'h0001;
      end
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         chk_dly <= 16'h0000;
      end else if (st != PCP_ST_DELAY) begin
         chk_dly <= 16'h0000;
      end else if (pclk_rise) begin
         chk_dly <= chk_dly + 16'h0001;
      end
   end
   sequence s_delay_end;
      st == PCP_ST_DELAY ##1 st == PCP_ST_RUN;
   endsequence
   a_delay_length: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      s_delay_end |-> chk_dly >= sync_to_data_delay) else $error("delay too short"); // R12
   a_frame_takes: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      frame_done_o |-> chk_takes == transfer_count) else $error("wrong sample count"); // R13
   a_656_receive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (en && is656) |-> (pd_oe_o == '0 && fs_oe_o == 3'h0)) else $error("656 driving"); // R5
   a_output_drive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (en && !is656 && xfr == PCP_XFR_OUTPUT) |-> pd_oe_o == '1) else $error("data not driven"); // R10
   a_rx_width: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      rx_o.valid |-> (rx_o.data & ~16'($past(wmask))) == 16'h0000) else $error("bits beyond width"); // R14
endmodule

// >>> pcp_pkg.sv
// package: constants and types for the parallel capture port
package pcp_pkg;
   // register offsets, byte addresses
   localparam logic [3:0] PCP_ADDR_CONFIG = 4'h0;
   localparam logic [3:0] PCP_ADDR_DELAY  = 4'h4;
   localparam logic [3:0] PCP_ADDR_COUNT  = 4'h8;
   localparam logic [3:0] PCP_ADDR_STATUS = 4'hC;
   // configuration field positions
   localparam int PCP_CFG_EN     = 0;
   localparam int PCP_CFG_DIR    = 1;
   localparam int PCP_CFG_XFR_LO = 2;
   localparam int PCP_CFG_XFR_HI = 3;
   localparam int PCP_CFG_656    = 4;
   localparam int PCP_CFG_WID_LO = 5;
   localparam int PCP_CFG_WID_HI = 7;
   localparam int PCP_CFG_FSO_LO = 8;
   localparam int PCP_CFG_FSO_HI = 10;
   localparam logic [15:0] PCP_CFG_RESET = 16'h0000;
   // width codes: 0 gives 8 bits, n gives 9+n bits
   localparam logic [2:0] PCP_WID_8  = 3'h0;
   localparam logic [4:0] PCP_WID_BASE = 5'h09;
   // timing reference words
   localparam logic [9:0] PCP_TRC_FF = 10'h3FF;
   localparam logic [9:0] PCP_TRC_00 = 10'h000;
   localparam int PCP_TRS_F = 8;
   localparam int PCP_TRS_V = 7;
   localparam int PCP_TRS_H = 6;

   typedef enum logic [1:0] {
      PCP_XFR_INPUT = 2'h0, PCP_XFR_CAPTURE = 2'h1, PCP_XFR_OUTPUT = 2'h2
   } pcp_xfr_t;
   typedef enum logic [1:0] {
      PCP_V_ACTIVE = 2'h0, PCP_V_VBLANK = 2'h1, PCP_V_FIELD = 2'h2
   } pcp_vmode_t;
   typedef enum logic [2:0] {
      PCP_ST_IDLE = 3'h0, PCP_ST_WAIT = 3'h1, PCP_ST_DELAY = 3'h3,
      PCP_ST_RUN = 3'h2, PCP_ST_DONE = 3'h6
   } pcp_state_t;

   // sample toward the system side
   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } pcp_sample_t;
endpackage

// >>> pcp_partner.sv
// peripheral model: port clock source, frame syncs and data toward the port
`timescale 1ns/1ps
module pcp_partner (
   // control from the bench
   input  wire logic        run_i,
   // pins toward the port
   output logic             pclk_o,
   output logic [2:0]       fs_o,
   output logic [15:0]      pd_o
);
   initial begin
      pclk_o = 1'b0;
      fs_o   = 3'h0;
      pd_o   = 16'h0000;
      forever begin
         #62.5;
         // well under half the system clock, stopped outside frames
         pclk_o = run_i ? ~pclk_o : 1'b0;
      end
   end
   // one word per port clock, changed on the falling edge
   task automatic send(input logic [15:0] w, input logic [2:0] f);
      @(negedge pclk_o);
      pd_o = w;
      fs_o = f;
   endtask
   // released lines: syncs low, data inverted every clock
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge pclk_o);
         fs_o = 3'h0;
         pd_o = ~pd_o;
      end
   endtask
endmodule

// >>> pcp_tb.sv
// self-checking bench for the parallel capture port
`timescale 1ns/1ps
module testbench;
   import pcp_pkg::*;
   logic        ref_clk_i, rst_i, wr_i, rd_i, run, port_clk, tx_take_o, frame_done_o;
   logic        fs0_seen, tx_seen, done_seen, w8;
   logic [3:0]  addr_i;
   logic [15:0] wdata_i, rdata_o, tx_data_i, pd_i, pd_o, pd_oe_o, pd_p, rv, first_rx, f16, f8;
   logic [2:0]  fs_i, fs_o, fs_oe_o, fs_p;
   pcp_sample_t rx_o;
   int          error_cnt, n_tests, rx_cnt, n_act, n_vbi, n_ctl, n_take, d, k, m;

   assign pd_i = (pd_oe_o & pd_o) | (~pd_oe_o & pd_p);
   assign fs_i = (fs_oe_o & fs_o) | (~fs_oe_o & fs_p);

   pcp_port #(.DW(16)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_clock_in_i(port_clk), .fs_i(fs_i), .fs_o(fs_o),
      .fs_oe_o(fs_oe_o), .pd_i(pd_i), .pd_o(pd_o), .pd_oe_o(pd_oe_o), .rx_o(rx_o), .tx_data_i(tx_data_i),
      .tx_take_o(tx_take_o), .frame_done_o(frame_done_o));
   pcp_partner p (.run_i(run), .pclk_o(port_clk), .fs_o(fs_p), .pd_o(pd_p));

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i) begin
      if (rx_o.valid === 1'b1) begin
         if (rx_cnt == 0) first_rx = rx_o.data;
         rx_cnt = rx_cnt + 1;
         n_act = n_act + (rx_o.data === 16'h0055);
         n_vbi = n_vbi + (rx_o.data === 16'h00CC);
         n_ctl = n_ctl + (rx_o.data === 16'h03FF);
      end
      n_take = n_take + (tx_take_o === 1'b1);
      fs0_seen = fs0_seen | (fs_o[0] & fs_oe_o[0]);
      tx_seen = tx_seen | (pd_oe_o[0] & (pd_o === 16'hA5C3));
      done_seen = done_seen | (frame_done_o === 1'b1);
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] dat);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= dat;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(posedge ref_clk_i);
      rv = rdata_o;
   endtask

   function automatic logic [15:0] cfg(input logic en, input logic [1:0] sub, input logic dir, input logic m656,
                                       input logic [2:0] wid, input logic [2:0] fso);
      return {5'h00, fso, wid, m656, sub, dir, en};
   endfunction

   task automatic restart();
      run = 1'b0;
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      {rx_cnt, n_act, n_vbi, n_ctl, n_take} = '0;
      {fs0_seen, tx_seen, done_seen} = 3'h0;
   endtask

   task automatic finish_frame();
      int i;
      for (i = 0; i < 40 && done_seen !== 1'b1; i++) p.idle(1);
      if (done_seen !== 1'b1) begin
         error_cnt++;
         final_report();
      end
   endtask

   // timing reference: three preamble words, then F=0 status
   task automatic trc(input logic v, input logic h);
      p.send(16'h03FF, 3'h0);
      p.send(16'h0000, 3'h0);
      p.send(16'h0000, 3'h0);
      p.send(w8 ? {8'h00, 1'b1, 1'b0, v, h, 4'h0} : {6'h00, 1'b1, 1'b0, v, h, 6'h00}, 3'h0);
   endtask

   task automatic line656(input logic v);
      int j;
      trc(v, 1'b1);
      for (j = 0; j < 4; j++) p.send(16'h00AA, 3'h0);
      trc(v, 1'b0);
      for (j = 0; j < 4; j++) p.send(v ? 16'h00CC : 16'h0055, 3'h0);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      {rst_i, wr_i, rd_i, run, addr_i, wdata_i} = {1'b1, 3'h0, 4'h0, 16'h0000};
      tx_data_i = 16'hA5C3;
      {error_cnt, n_tests} = '0;
      repeat (8) @(posedge ref_clk_i);
      restart();
      rd(PCP_ADDR_CONFIG);
      check(rv, PCP_CFG_RESET);
      rd(4'h2);
      check(rv, 16'h0000);
      wr(PCP_ADDR_DELAY, 16'h0005);
      wr(PCP_ADDR_COUNT, 16'h0004);
      rd(PCP_ADDR_DELAY);
      check(rv, 16'h0005);
      rd(PCP_ADDR_COUNT);
      check(rv, 16'h0004);
      wr(PCP_ADDR_CONFIG, cfg(1'b0, PCP_XFR_OUTPUT, 1'b1, 1'b0, 3'h7, 3'h7));
      check(pd_oe_o, 16'h0000);
      check({13'h0000, fs_oe_o}, 16'h0000);
      // two input frames: different delays and widths
      for (d = 0; d < 2; d++) begin
         restart();
         wr(PCP_ADDR_DELAY, d ? 16'h0005 : 16'h0002);
         wr(PCP_ADDR_COUNT, 16'h0004);
         wr(PCP_ADDR_CONFIG, cfg(1'b1, PCP_XFR_INPUT, 1'b0, 1'b0, d ? PCP_WID_8 : 3'h7, 3'h0));
         run = 1'b1;
         p.send(16'hAB00, 3'h1);
         for (k = 1; k < 20; k++) p.send({8'hAB, k[7:0]}, 3'h0);
         finish_frame();
         check({13'h0000, fs_oe_o}, 16'h0000);
         check(pd_oe_o, 16'h0000);
         check(rx_cnt[15:0], 16'h0004);
         if (d) f8 = first_rx;
         else f16 = first_rx;
      end
      check({8'h00, f16[15:8]}, 16'h00AB);
      check({8'h00, f8[15:8]}, 16'h0000);
      check({8'h00, f8[7:0] - f16[7:0]}, 16'h0003);
      // frame capture
      restart();
      wr(PCP_ADDR_DELAY, 16'h0002);
      wr(PCP_ADDR_COUNT, 16'h0004);
      wr(PCP_ADDR_CONFIG, cfg(1'b1, PCP_XFR_CAPTURE, 1'b0, 1'b0, 3'h7, 3'h0));
      run = 1'b1;
      for (k = 0; k < 8; k++) p.send(k[15:0], 3'h0);
      finish_frame();
      check({14'h0000, fs_oe_o[1:0]}, 16'h0003);
      check(pd_oe_o, 16'h0000);
      check({15'h0000, fs0_seen}, 16'h0001);
      check(rx_cnt[15:0], 16'h0004);
      // output
      restart();
      wr(PCP_ADDR_DELAY, 16'h0002);
      wr(PCP_ADDR_COUNT, 16'h0004);
      wr(PCP_ADDR_CONFIG, cfg(1'b1, PCP_XFR_OUTPUT, 1'b1, 1'b0, 3'h7, 3'h7));
      run = 1'b1;
      finish_frame();
      check(pd_oe_o, 16'hFFFF);
      check({13'h0000, fs_oe_o}, 16'h0007);
      check(n_take[15:0], 16'h0004);
      check({15'h0000, tx_seen}, 16'h0001);
      // 656 modes: two blanking lines, three active, one blanking
      for (m = 0; m < 3; m++) begin
         restart();
         w8 = (m == 1);
         wr(PCP_ADDR_COUNT, 16'h0002);
         wr(PCP_ADDR_CONFIG, cfg(1'b1, m[1:0], 1'b0, 1'b1, w8 ? PCP_WID_8 : 3'h1, 3'h0));
         run = 1'b1;
         for (k = 0; k < 6; k++) line656(k < 2 || k == 5);
         for (k = 0; k < 3; k++) p.send(16'h0000, 3'h0);
         if (m == 0) begin
            check(n_act[15:0], 16'h0008);
            check(rx_cnt[15:0], 16'h0008);
         end else if (m == 1) begin
            check(n_act[15:0], 16'h0000);
            check({15'h0000, n_vbi != 0}, 16'h0001);
         end else begin
            check(n_act[15:0], 16'h000C);
            check({15'h0000, n_ctl != 0}, 16'h0001);
            check(first_rx, 16'h00AA);
            rd(PCP_ADDR_STATUS);
            check({15'h0000, rv[7]}, 16'h0001);
         end
      end
      final_report();
   end
endmodule
